// ==== chop_ctrl_pkg.sv ====
// constants, types and register map of the quad half-bridge chop controller
package chop_ctrl_pkg;
	localparam int CLK_MHZ = 50;
	localparam int CH_N = 4;
	localparam int CNT_W = 11;
	localparam int BLANK_NS = 1000;
	localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
	localparam int OFF0_NS = 7000;
	localparam int OFF1_NS = 16000;
	localparam int OFF2_NS = 24000;
	localparam int OFF3_NS = 32000;
	localparam logic [CNT_W-1:0] OFF_CYC_TBL [4] = '{
		CNT_W'(OFF0_NS * CLK_MHZ / 1000), CNT_W'(OFF1_NS * CLK_MHZ / 1000),
		CNT_W'(OFF2_NS * CLK_MHZ / 1000), CNT_W'(OFF3_NS * CLK_MHZ / 1000)};
	localparam int DEGLITCH_NS = 10000;
	localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_MIN_NS = 20000;
	localparam int PULSE_MIN_CYC = PULSE_MIN_NS * CLK_MHZ / 1000;
	localparam int PULSE_MAX_NS = 40000;
	localparam int PULSE_MAX_CYC = PULSE_MAX_NS * CLK_MHZ / 1000;
	localparam int WAKE_NS = 1000;
	localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] INT_STAT_OFS = 12'h008;
	localparam logic [11:0] INT_MASK_OFS = 12'h00c;
	localparam int CTRL_CHOP_BIT = 0;
	localparam logic CTRL_CHOP_RESET = 1'b1;
	localparam int STAT_SEL_LSB = 0;
	localparam int STAT_AWAKE_BIT = 2;
	localparam int STAT_FAULT_BIT = 3;
	localparam int STAT_LATCH_BIT = 4;
	localparam int STAT_HS_LSB = 8;
	localparam int STAT_LS_LSB = 12;
	localparam int INT_W = 4;
	localparam int INT_TRIP = 0;
	localparam int INT_FAULT = 1;
	localparam int INT_WAKE = 2;
	localparam int INT_SEL = 3;
	typedef enum logic [1:0] {
		CH_HIGH = 2'b00,
		CH_LOWBLANK = 2'b01,
		CH_LOWSENSE = 2'b10,
		CH_OFFTIME = 2'b11
	} chop_state_t;
	typedef struct packed {
		logic [CH_N-1:0] highOn;
		logic [CH_N-1:0] lowOn;
	} bridge_drive_t;
endpackage

// ==== quad_half_bridge_chop_control.sv ====
// control logic of a four-channel half-bridge driver with fixed off-time chopping
// Notes on behaviour
// - while the standby request is low every half-bridge output is high impedance.
// - while awake and without a fault each output follows its command, low turns on low side, high turns on high side.
// - with a low command the low side stays on until the trip is reached, then high side turns on.
// - after the selected off-time the low side turns on again and the cycle repeats.
// - the off-time comes from the four-level off-time select input.
// - the four off-times are 7, 16, 24 and 32 us.
// - a new off-time selection applies only after being stable for 10 us.
// - each low-side turn-on masks the comparator for about 1 us, the least on-time.
// - channels 1 and 2 use the first reference pair, channels 3 and 4 the second.
// - chopping regulates by itself, even with the command held low all the time.
// - the open-drain fault flag is pulled low while a fault exists and released otherwise.
// - after reset, or after the standby request rises from a low of more than 40 us, a wake interval passes before inputs are taken.
// - a standby low pulse of more than 20 and less than 40 us clears latched faults only.
//
// Local design decisions: the APB slave port and the register addresses.
module quad_half_bridge_chop_control #(
	parameter int WAKE_CYC = chop_ctrl_pkg::WAKE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic standbyRequestN,
	input wire logic [3:0] channelCommand,
	input wire logic [1:0] offTimeSelect,
	input wire logic [1:0] tripPairA,
	input wire logic [1:0] tripPairB,
	input wire logic faultAutoIn,
	input wire logic faultLatchIn,
	output chop_ctrl_pkg::bridge_drive_t bridgeDrive,
	output logic faultFlagNOut,
	output logic faultFlagNOe,
	output logic irq
);
	localparam logic [10:0] BLANK_LAST = 11'(chop_ctrl_pkg::BLANK_CYC - 1);
	localparam logic [10:0] DEGL_LAST = 11'(chop_ctrl_pkg::DEGLITCH_CYC - 1);
	localparam logic [10:0] PMIN = 11'(chop_ctrl_pkg::PULSE_MIN_CYC);
	localparam logic [10:0] PMAX = 11'(chop_ctrl_pkg::PULSE_MAX_CYC);
	localparam logic [10:0] WAKE_LAST = 11'(WAKE_CYC - 1);
	localparam logic [10:0] LOW_MIN = 11'(chop_ctrl_pkg::BLANK_CYC);

	chop_ctrl_pkg::chop_state_t chState_ff [4];
	chop_ctrl_pkg::chop_state_t nxt_chState [4];
	logic [10:0] chCnt_ff [4];
	logic [10:0] nxt_chCnt [4];
	logic chopEn_ff;
	logic [3:0] intStat_ff;
	logic [3:0] intMask_ff;
	logic [1:0] selSeen_ff;
	logic [1:0] activeSel_ff;
	logic [10:0] selCnt_ff;
	logic [10:0] lowCnt_ff;
	logic [10:0] wakeCnt_ff;
	logic awake_ff;
	logic latched_ff;
	logic faultPrev_ff;
	logic faultOe_ff;
	logic [10:0] lowRun_ff;

	wire faultActive = faultAutoIn | latched_ff;
	wire driveEn = standbyRequestN & awake_ff & ~faultActive;
	wire [3:0] tripHit = {tripPairB, tripPairA};
	wire [10:0] offCyc = chop_ctrl_pkg::OFF_CYC_TBL[activeSel_ff];
	wire selApply = (selSeen_ff == offTimeSelect) && (selCnt_ff == DEGL_LAST);
	wire clearPulse = standbyRequestN && (lowCnt_ff > PMIN) && (lowCnt_ff < PMAX);
	wire wakeDone = standbyRequestN && !awake_ff && (wakeCnt_ff == WAKE_LAST);
	wire [3:0] offNow;
	wire [3:0] tripEvt;

	// per-channel chopping state machine
	for (genvar c = 0; c < 4; c++) begin : g_ch
		assign offNow[c] = chState_ff[c] == chop_ctrl_pkg::CH_OFFTIME;
		assign tripEvt[c] = (chState_ff[c] == chop_ctrl_pkg::CH_LOWSENSE)
			&& (nxt_chState[c] == chop_ctrl_pkg::CH_OFFTIME);
		assign bridgeDrive.lowOn[c] = driveEn & ~channelCommand[c] & ~offNow[c];
		assign bridgeDrive.highOn[c] = driveEn & (channelCommand[c] | offNow[c]);
		always_comb begin
			nxt_chState[c] = chState_ff[c];
			nxt_chCnt[c] = chCnt_ff[c];
			if (!driveEn || channelCommand[c]) begin
				nxt_chState[c] = chop_ctrl_pkg::CH_HIGH;
				nxt_chCnt[c] = 11'h000;
			end else begin
				unique case (chState_ff[c])
					chop_ctrl_pkg::CH_HIGH: begin
						nxt_chState[c] = chop_ctrl_pkg::CH_LOWBLANK;
						nxt_chCnt[c] = 11'h000;
					end
					chop_ctrl_pkg::CH_LOWBLANK: begin
						if (chCnt_ff[c] == BLANK_LAST) begin
							nxt_chState[c] = chop_ctrl_pkg::CH_LOWSENSE;
						end else begin
							nxt_chCnt[c] = chCnt_ff[c] + 11'h001;
						end
					end
					chop_ctrl_pkg::CH_LOWSENSE: begin
						if (tripHit[c] && chopEn_ff) begin
							nxt_chState[c] = chop_ctrl_pkg::CH_OFFTIME;
							nxt_chCnt[c] = 11'h000;
						end
					end
					chop_ctrl_pkg::CH_OFFTIME: begin
						if (chCnt_ff[c] >= offCyc - 11'h001) begin
							nxt_chState[c] = chop_ctrl_pkg::CH_LOWBLANK;
							nxt_chCnt[c] = 11'h000;
						end else begin
							nxt_chCnt[c] = chCnt_ff[c] + 11'h001;
						end
					end
				endcase
			end
		end
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				chState_ff[c] <= chop_ctrl_pkg::CH_HIGH;
				chCnt_ff[c] <= 11'h000;
			end else if (clkEn) begin
				chState_ff[c] <= nxt_chState[c];
				chCnt_ff[c] <= nxt_chCnt[c];
			end
		end
	end

	// off-time select deglitch
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			selSeen_ff <= 2'h0;
			activeSel_ff <= 2'h0;
			selCnt_ff <= 11'h000;
		end else if (clkEn) begin
			selSeen_ff <= offTimeSelect;
			if (selSeen_ff != offTimeSelect) begin
				selCnt_ff <= 11'h000;
			end else if (selApply) begin
				activeSel_ff <= selSeen_ff;
				selCnt_ff <= 11'h000;
			end else begin
				selCnt_ff <= selCnt_ff + 11'h001;
			end
		end
	end

	// standby, wake and fault-clear pulse
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lowCnt_ff <= 11'h000;
			wakeCnt_ff <= 11'h000;
			awake_ff <= 1'b0;
		end else if (clkEn) begin
			if (standbyRequestN) begin
				lowCnt_ff <= 11'h000;
			end else if (lowCnt_ff != PMAX) begin
				lowCnt_ff <= lowCnt_ff + 11'h001;
			end
			if (!standbyRequestN && lowCnt_ff == PMAX) begin
				awake_ff <= 1'b0;
				wakeCnt_ff <= 11'h000;
			end else if (wakeDone) begin
				awake_ff <= 1'b1;
			end else if (standbyRequestN && !awake_ff) begin
				wakeCnt_ff <= wakeCnt_ff + 11'h001;
			end
		end
	end

	// fault latch and open-drain flag
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			latched_ff <= 1'b0;
			faultPrev_ff <= 1'b0;
			faultOe_ff <= 1'b0;
		end else if (clkEn) begin
			if (faultLatchIn) begin
				latched_ff <= 1'b1;
			end else if (clearPulse) begin
				latched_ff <= 1'b0;
			end
			faultPrev_ff <= faultActive;
			faultOe_ff <= faultActive;
		end
	end
	assign faultFlagNOut = 1'b0;
	assign faultFlagNOe = faultOe_ff;

	// apb slave, zero wait states
	wire apbWr = psel & penable & pwrite;
	wire hitCtrl = paddr == chop_ctrl_pkg::CTRL_OFS;
	wire hitStat = paddr == chop_ctrl_pkg::STATUS_OFS;
	wire hitInt = paddr == chop_ctrl_pkg::INT_STAT_OFS;
	wire hitMask = paddr == chop_ctrl_pkg::INT_MASK_OFS;
	wire [3:0] intEvt;
	wire [31:0] statusWord;
	assign intEvt[chop_ctrl_pkg::INT_TRIP] = |tripEvt;
	assign intEvt[chop_ctrl_pkg::INT_FAULT] = faultActive & ~faultPrev_ff;
	assign intEvt[chop_ctrl_pkg::INT_WAKE] = wakeDone;
	assign intEvt[chop_ctrl_pkg::INT_SEL] = selApply && (selSeen_ff != activeSel_ff);
	assign statusWord = {16'h0000, bridgeDrive.lowOn, bridgeDrive.highOn, 3'h0,
		latched_ff, faultActive, awake_ff, activeSel_ff};
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~(hitCtrl | hitStat | hitInt | hitMask);
	assign prdata = !(psel && !pwrite) ? 32'h0000_0000 :
		hitCtrl ? {31'h0000_0000, chopEn_ff} :
		hitStat ? statusWord :
		hitInt ? {28'h000_0000, intStat_ff} :
		hitMask ? {28'h000_0000, intMask_ff} : 32'h0000_0000;
	assign irq = |(intStat_ff & intMask_ff);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chopEn_ff <= chop_ctrl_pkg::CTRL_CHOP_RESET;
			intStat_ff <= 4'h0;
			intMask_ff <= 4'h0;
		end else if (clkEn) begin
			if (apbWr && hitCtrl) begin
				chopEn_ff <= pwdata[chop_ctrl_pkg::CTRL_CHOP_BIT];
			end
			if (apbWr && hitMask) begin
				intMask_ff <= pwdata[3:0];
			end
			intStat_ff <= (intStat_ff & ~((apbWr && hitInt) ? pwdata[3:0] : 4'h0)) | intEvt;
		end
	end

	// low-side on-time run of channel 1, for the blanking check
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lowRun_ff <= 11'h000;
		end else if (clkEn) begin
			if (!bridgeDrive.lowOn[0]) begin
				lowRun_ff <= 11'h000;
			end else if (lowRun_ff != 11'h7ff) begin
				lowRun_ff <= lowRun_ff + 11'h001;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_sleep_hiz;
		!standbyRequestN |-> (bridgeDrive.highOn == 4'h0) && (bridgeDrive.lowOn == 4'h0);
	endproperty
	a_sleep_hiz: assert property (p_sleep_hiz) else $error("output driven in standby");

	property p_follow;
		driveEn |-> ((bridgeDrive.highOn & channelCommand) == channelCommand)
			&& ((bridgeDrive.lowOn & channelCommand) == 4'h0);
	endproperty
	a_follow: assert property (p_follow) else $error("high command not on high side");

	sequence s_trip0;
		clkEn && driveEn && !channelCommand[0] && chopEn_ff
			&& chState_ff[0] == chop_ctrl_pkg::CH_LOWSENSE && tripHit[0];
	endsequence
	property p_trip;
		s_trip0 |=> offNow[0] && !bridgeDrive.lowOn[0];
	endproperty
	a_trip: assert property (p_trip) else $error("trip did not start off-time");

	property p_off_end;
		clkEn && driveEn && !channelCommand[0] && offNow[0] && chCnt_ff[0] == offCyc - 11'h001
			|=> chState_ff[0] == chop_ctrl_pkg::CH_LOWBLANK;
	endproperty
	a_off_end: assert property (p_off_end) else $error("off-time did not end");

	property p_off_len;
		offNow[0] && $stable(activeSel_ff) |-> chCnt_ff[0] < offCyc;
	endproperty
	a_off_len: assert property (p_off_len) else $error("off-time overran");

	property p_blank;
		tripEvt[0] |-> lowRun_ff >= LOW_MIN;
	endproperty
	a_blank: assert property (p_blank) else $error("trip taken in blanking");

	property p_degl;
		$changed(activeSel_ff) |-> $past(selCnt_ff) == DEGL_LAST;
	endproperty
	a_degl: assert property (p_degl) else $error("select applied early");

	property p_fault_flag;
		clkEn && faultActive |=> faultFlagNOe && !faultFlagNOut;
	endproperty
	a_fault_flag: assert property (p_fault_flag) else $error("fault flag not low");

	property p_clear;
		clkEn && clearPulse && !faultLatchIn |=> !latched_ff && (awake_ff || !$past(awake_ff));
	endproperty
	a_clear: assert property (p_clear) else $error("reset pulse mishandled");

	property p_wake;
		$rose(awake_ff) |-> $past(wakeCnt_ff) == WAKE_LAST && $past(standbyRequestN);
	endproperty
	a_wake: assert property (p_wake) else $error("woke before wake interval");
endmodule

// ==== chop_controller_model.sv ====
// controller model driving standby and command inputs, with the fault line pull-up
module chop_controller_model #(
	parameter int WAKE_WAIT = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic standbyGo,
	input wire logic [3:0] cmdReq,
	input wire logic faultFlagNOut,
	input wire logic faultFlagNOe,
	output logic standbyRequestN,
	output logic [3:0] channelCommand,
	output logic faultFlagN,
	output logic ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] wakeCnt_ff;
	assign standbyRequestN = standbyGo;
	// commands held high until the wake interval has run out
	assign ready = (wakeCnt_ff >= 8'(WAKE_WAIT + 2));
	assign channelCommand = ready ? cmdReq : 4'hf;
	// open-drain line with pull-up
	assign faultFlagN = faultFlagNOe ? faultFlagNOut : 1'b1;
	always_ff @(posedge clk) begin
		if (!rst_n || !standbyGo) begin
			wakeCnt_ff <= 8'h00;
		end else if (!ready) begin
			wakeCnt_ff <= wakeCnt_ff + 8'h01;
		end
	end
endmodule

// ==== quad_half_bridge_chop_control_tb_top.sv ====
// self-checking bench of the chop controller
module quad_half_bridge_chop_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WAKE = 3;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, standbyGo = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, faultAutoIn = 0, faultLatchIn = 0, irq;
	logic [3:0] cmdReq = 4'hf, channelCommand, t;
	logic [1:0] offTimeSelect = 2'h0, tripPairA = 2'h0, tripPairB = 2'h0;
	logic faultFlagNOut, faultFlagNOe, faultFlagN, ready, standbyRequestN;
	chop_ctrl_pkg::bridge_drive_t bridgeDrive;
	int nFail = 0, testsRun = 0, cycles = 0, len, n;
	always #10 clk = ~clk;
	quad_half_bridge_chop_control #(.WAKE_CYC(WAKE)) dut (.clk(clk), .rst_n(rst_n),
		.clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.standbyRequestN(standbyRequestN), .channelCommand(channelCommand),
		.offTimeSelect(offTimeSelect), .tripPairA(tripPairA), .tripPairB(tripPairB),
		.faultAutoIn(faultAutoIn), .faultLatchIn(faultLatchIn), .bridgeDrive(bridgeDrive),
		.faultFlagNOut(faultFlagNOut), .faultFlagNOe(faultFlagNOe), .irq(irq));
	chop_controller_model #(.WAKE_WAIT(WAKE)) ctl (.clk(clk), .rst_n(rst_n),
		.standbyGo(standbyGo), .cmdReq(cmdReq), .faultFlagNOut(faultFlagNOut),
		.faultFlagNOe(faultFlagNOe), .standbyRequestN(standbyRequestN),
		.channelCommand(channelCommand), .faultFlagN(faultFlagN), .ready(ready));
	task automatic closeOut();
		if (nFail == 0 && testsRun > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			nFail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apbXfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdChk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apbXfer(1'b0, a, 32'h0);
		check(rd & m, e);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic measOff(input int ch, output int l);
		n = 0;
		while (bridgeDrive.highOn[ch] !== 1'b0 && n < 4000) begin
			cyc(1);
			n++;
		end
		while (bridgeDrive.highOn[ch] !== 1'b1 && n < 8000) begin
			cyc(1);
			n++;
		end
		l = 0;
		while (bridgeDrive.highOn[ch] === 1'b1 && l < 4000) begin
			cyc(1);
			l++;
		end
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles > 60000) begin
			nFail++;
			closeOut();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
		check(32'(bridgeDrive), 32'h0);
		check(32'(faultFlagN), 32'h1);
		rdChk(chop_ctrl_pkg::CTRL_OFS, 32'hffffffff, 32'h1);
		rdChk(chop_ctrl_pkg::INT_MASK_OFS, 32'hffffffff, 32'h0);
		apbXfer(1'b0, 12'h010, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		@(posedge clk) standbyGo <= 1'b1;
		n = 0;
		while (ready !== 1'b1 && n < 100) begin cyc(1); n++; end
		check(32'(ready), 32'h1);
		rdChk(chop_ctrl_pkg::STATUS_OFS, 32'h4, 32'h4);
		cyc(1);
		check(32'(bridgeDrive), 32'hf0);
		for (int i = 0; i < 4; i++) begin
			t = 4'(1 << i);
			@(posedge clk);
			tripPairA <= t[1:0];
			tripPairB <= t[3:2];
			cmdReq <= 4'h0;
			cyc(1);
			check(32'(bridgeDrive), 32'h0f);
			cyc(45);
			check(32'(bridgeDrive.highOn), 32'h0);
			cyc(15);
			check(32'(bridgeDrive.highOn), 32'(t));
			@(posedge clk) cmdReq <= 4'hf;
		end
		@(posedge clk);
		tripPairA <= 2'h1;
		cmdReq <= 4'he;
		for (int s = 0; s < 4; s++) begin
			if (s > 0) begin
				@(posedge clk) offTimeSelect <= 2'(s);
				cyc(400);
				rdChk(chop_ctrl_pkg::STATUS_OFS, 32'h3, 32'(s - 1));
				cyc(200);
				rdChk(chop_ctrl_pkg::STATUS_OFS, 32'h3, 32'(s));
			end
			for (int r = 0; r < 2; r++) begin
				measOff(0, len);
				check(32'(len >= chop_ctrl_pkg::OFF_CYC_TBL[s] - 1), 32'h1);
				check(32'(len <= chop_ctrl_pkg::OFF_CYC_TBL[s] + 1), 32'h1);
			end
		end
		@(posedge clk);
		cmdReq <= 4'hf;
		tripPairA <= 2'h0;
		cyc(5);
		rdChk(chop_ctrl_pkg::INT_STAT_OFS, 32'hf, 32'hd);
		check(32'(irq), 32'h0);
		apbXfer(1'b1, chop_ctrl_pkg::INT_MASK_OFS, 32'h1);
		cyc(1);
		check(32'(irq), 32'h1);
		apbXfer(1'b1, chop_ctrl_pkg::INT_STAT_OFS, 32'hf);
		cyc(1);
		check(32'(irq), 32'h0);
		rdChk(chop_ctrl_pkg::INT_STAT_OFS, 32'hf, 32'h0);
		apbXfer(1'b1, chop_ctrl_pkg::CTRL_OFS, 32'h0);
		@(posedge clk);
		tripPairA <= 2'h1;
		cmdReq <= 4'he;
		cyc(100);
		check(32'(bridgeDrive), 32'he1);
		@(posedge clk);
		cmdReq <= 4'hf;
		tripPairA <= 2'h0;
		apbXfer(1'b1, chop_ctrl_pkg::CTRL_OFS, 32'h1);
		rdChk(chop_ctrl_pkg::CTRL_OFS, 32'h1, 32'h1);
		rdChk(chop_ctrl_pkg::INT_STAT_OFS, 32'h1, 32'h0);
		@(posedge clk) faultAutoIn <= 1'b1;
		cyc(2);
		check(32'(faultFlagN), 32'h0);
		check(32'(bridgeDrive), 32'h0);
		rdChk(chop_ctrl_pkg::INT_STAT_OFS, 32'h2, 32'h2);
		@(posedge clk) faultAutoIn <= 1'b0;
		cyc(3);
		check(32'(faultFlagN), 32'h1);
		@(posedge clk) faultLatchIn <= 1'b1;
		@(posedge clk) faultLatchIn <= 1'b0;
		cyc(50);
		check(32'(faultFlagN), 32'h0);
		@(posedge clk) standbyGo <= 1'b0;
		cyc(1500);
		check(32'(bridgeDrive), 32'h0);
		@(posedge clk) standbyGo <= 1'b1;
		cyc(3);
		check(32'(faultFlagN), 32'h1);
		rdChk(chop_ctrl_pkg::STATUS_OFS, 32'h4, 32'h4);
		closeOut();
	end
endmodule
